// *** irs_cfg.svh ***
`ifndef IRS_CFG_SVH
`define IRS_CFG_SVH
// register map
`define IRS_ADR_MISC   8'h20
`define IRS_ADR_STAT   8'h25
`define IRS_MISC_RST   8'h00
// status bit positions
`define IRS_B_LVD      4
`define IRS_B_CLOCK_GUARD_IRQ_ENABLE    2
`define IRS_B_BACKUP_OSC_ACTIVE_FLAG     1
`define IRS_B_WDG      0
// control bit positions
`define IRS_B_POL3     7
`define IRS_B_POL2     6
`define IRS_B_MCO      5
`define IRS_B_POL1     4
`define IRS_B_POL0     3
`define IRS_B_CP1      2
`define IRS_B_CP0      1
`define IRS_B_SMS      0
// sources: 0 ei0, 1 ei1, 2 clock guard, 3..9 peripherals
`define IRS_NSRC       10
`define IRS_NPER       7
`define IRS_SRC_TRAP   4'hf
`define IRS_HALT_MASK  10'h1e3
// sensitivity codes
`define IRS_SEN_LOW    2'h0
`define IRS_SEN_RISE   2'h1
`define IRS_SEN_FALL   2'h2
// stacked register codes
`define IRS_SEL_PCL    3'h0
`define IRS_SEL_CC     3'h4
`define IRS_LAST_STEP  3'h4
// vectors
`define IRS_VEC_TRAP   16'hfffc
`define IRS_VEC_SCI    16'hffe4
`define IRS_VEC_TOP    16'hfffa
`endif

// *** irs_pkg.sv ***
package irs_pkg;
   typedef enum logic [1:0] {
      IRS_IDLE = 2'b00,
      IRS_PUSH = 2'b01,
      IRS_VEC  = 2'b10,
      IRS_POP  = 2'b11
   } irs_state_type;
   typedef struct packed {
      irs_state_type st;
      logic [2:0]    step;
      logic [3:0]    src;
      logic [15:0]   vec;
      logic          imask;
      logic [7:0]    misc;
      logic          supply_drop_detector;
      logic          wdg;
      logic          clock_guard_irq_enable;
      logic          backup_osc_active_flag;
      logic [1:0]    ext_prev;
      logic [1:0]    ext_lat;
      logic [6:0]    per_prev;
      logic [6:0]    per_pend;
      logic [7:0]    rdata;
      logic          push;
      logic          pop;
      logic          pc_load;
      logic [2:0]    sel;
   } irs_regs_type;
endpackage

// *** irs_ctrl.sv ***
`timescale 1ns/100ps
`include "irs_cfg.svh"
// Operation
// - supply-drop flag set, cleared by zero/watchdog
// - watchdog flag set, cleared by zero/supply-drop
// - flags encode last reset source
// - clock-guard enable gates backup-osc interrupt
// - backup flag set, cleared by read after recovery
// - control at 20h, status at 25h
// - maskable service only while mask clear
// - entry waits for instruction end
// - entry pushes PC, X, A, CC
// - entry sets interrupt mask
// - vector loaded into program counter
// - return pops registers, clears mask
// - fixed hardware priority among pending
// - any wakes wait, some wake halt
// - trap enters regardless of mask
// - external vectors need mask clear, wake halt
// - external sensitivity from control bits
// - edge request latched, cleared on entry
// - pins on one line ANDed first
// - peripheral request needs enable, else pending
// - peripheral clear discards pending request
// - halt freezes status, no clock-guard wake
module irs_ctrl (
   // clock, reset, enable
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   input  wire logic                   ce,
   // register port
   input  wire logic [7:0]             addr,
   input  wire logic [7:0]             wdata,
   input  wire logic                   wr,
   input  wire logic                   rd,
   output logic [7:0]                  rdata,
   // reset and clock monitors
   input  wire logic                   supply_drop_rst,
   input  wire logic                   watchdog_rst,
   input  wire logic                   backup_osc_sel,
   // external lines: pins and their enables
   input  wire logic [7:0]             ei0_pin,
   input  wire logic [7:0]             ei0_en,
   input  wire logic [7:0]             ei1_pin,
   input  wire logic [7:0]             ei1_en,
   // peripheral flags, enables, clear sequences
   input  wire logic [`IRS_NPER-1:0]   per_flag,
   input  wire logic [`IRS_NPER-1:0]   per_en,
   input  wire logic [`IRS_NPER-1:0]   per_clr,
   // cpu side
   input  wire logic                   instr_end,
   input  wire logic                   trap_exec,
   input  wire logic                   return_from_interrupt,
   input  wire logic                   mask_set,
   input  wire logic                   mask_clr,
   input  wire logic                   wait_mode,
   input  wire logic                   halt_mode,
   output logic                        imask,
   output logic                        stk_push,
   output logic                        stk_pop,
   output logic [2:0]                  stk_sel,
   output logic                        pc_load,
   output logic [15:0]                 pc_vector,
   output logic                        wake_wait,
   output logic                        wake_halt,
   // clock control outputs
   output logic                        clock_out_enable,
   output logic [1:0]                  cpu_divider_sel,
   output logic                        slow_mode_select
);
   import irs_pkg::*;

   irs_regs_type q;
   irs_regs_type d;
   logic [1:0]   ext_lvl;
   logic [1:0]   ext_req;
   logic [1:0]   sen [2];
   logic [`IRS_NSRC-1:0] req;
   logic         any_req;
   logic [3:0]   pick;
   logic [15:0]  pick_vec;

   // ==========================================================
   // request gathering
   // ==========================================================
   // polarity fields per external line
   assign sen[0] = {q.misc[`IRS_B_POL1], q.misc[`IRS_B_POL0]};
   assign sen[1] = {q.misc[`IRS_B_POL3], q.misc[`IRS_B_POL2]};
   // pins of one line ANDed, disabled pins read high
   assign ext_lvl[0] = &(ei0_pin | ~ei0_en);
   assign ext_lvl[1] = &(ei1_pin | ~ei1_en);

   // low level requests directly, edges come from the latch
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         ext_req[k] = (sen[k] == `IRS_SEN_LOW) ? ~ext_lvl[k] : q.ext_lat[k];
      end
   end

   // request vector in priority order
   assign req = {q.per_pend & per_en, q.backup_osc_active_flag & q.clock_guard_irq_enable, ext_req};
   assign any_req = |req;

   // lowest index wins
   always_comb begin
      pick = 4'h0;
      for (int i = `IRS_NSRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            pick = i[3:0];
         end
      end
   end

   // vector table, two bytes per source, serial last
   always_comb begin
      if (pick == 4'(`IRS_NSRC - 1)) begin
         pick_vec = `IRS_VEC_SCI;
      end else begin
         pick_vec = `IRS_VEC_TOP - {11'h000, pick, 1'b0};
      end
   end

   // low-power wake requests
   assign wake_wait = wait_mode & any_req;
   assign wake_halt = halt_mode & |(req & `IRS_HALT_MASK);

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      d = q;
      d.push = 1'b0;
      d.pop = 1'b0;
      d.pc_load = 1'b0;
      if (ce) begin
         // external edge detection and latching
         d.ext_prev = ext_lvl;
         for (int k = 0; k < 2; k++) begin
            if (sen[k] == `IRS_SEN_RISE && ext_lvl[k] && !q.ext_prev[k]) begin
               d.ext_lat[k] = 1'b1;
            end
            if (sen[k] == `IRS_SEN_FALL && !ext_lvl[k] && q.ext_prev[k]) begin
               d.ext_lat[k] = 1'b1;
            end
            if (&sen[k] && ext_lvl[k] != q.ext_prev[k]) begin
               d.ext_lat[k] = 1'b1;
            end
         end
         // peripheral pending latch, the clear sequence drops it
         d.per_prev = per_flag;
         d.per_pend = (q.per_pend & ~per_clr) | (per_flag & ~q.per_prev);
         // mask instructions and low-power forcing
         if (mask_set) begin
            d.imask = 1'b1;
         end
         if (mask_clr || wait_mode || halt_mode) begin
            d.imask = 1'b0;
         end
         // control register write
         if (wr && addr == `IRS_ADR_MISC) begin
            d.misc = wdata;
         end
         // status register, frozen while halted
         if (!halt_mode) begin
            if (wr && addr == `IRS_ADR_STAT) begin
               d.clock_guard_irq_enable = wdata[`IRS_B_CLOCK_GUARD_IRQ_ENABLE];
               if (!wdata[`IRS_B_LVD]) begin
                  d.supply_drop_detector = 1'b0;
               end
               if (!wdata[`IRS_B_WDG]) begin
                  d.wdg = 1'b0;
               end
            end
            if (rd && addr == `IRS_ADR_STAT && !backup_osc_sel) begin
               d.backup_osc_active_flag = 1'b0;
            end
            if (backup_osc_sel) begin
               d.backup_osc_active_flag = 1'b1;
            end
            if (watchdog_rst) begin
               d.wdg = 1'b1;
               d.supply_drop_detector = 1'b0;
            end
            if (supply_drop_rst) begin
               d.supply_drop_detector = 1'b1;
               d.wdg = 1'b0;
            end
         end
         // registered read data
         if (rd) begin
            case (addr)
               `IRS_ADR_MISC: d.rdata = q.misc;
               `IRS_ADR_STAT: d.rdata = {3'h0, q.supply_drop_detector, 1'h0, q.clock_guard_irq_enable, q.backup_osc_active_flag, q.wdg};
               default:       d.rdata = 8'h00;
            endcase
         end
         // entry and return sequencer
         case (q.st)
            IRS_IDLE: begin
               if (instr_end && trap_exec) begin
                  d.st = IRS_PUSH;
                  d.src = `IRS_SRC_TRAP;
                  d.vec = `IRS_VEC_TRAP;
                  d.step = 3'h0;
               end else if (instr_end && any_req && !q.imask) begin
                  d.st = IRS_PUSH;
                  d.src = pick;
                  d.vec = pick_vec;
                  d.step = 3'h0;
                  if (pick < 4'h2) begin
                     d.ext_lat[pick[0]] = 1'b0;
                  end
               end else if (return_from_interrupt) begin
                  d.st = IRS_POP;
                  d.step = 3'h0;
               end
            end
            IRS_PUSH: begin
               d.push = 1'b1;
               d.sel = `IRS_SEL_PCL + q.step;
               d.step = q.step + 3'h1;
               if (q.step == `IRS_LAST_STEP) begin
                  d.st = IRS_VEC;
                  d.imask = 1'b1;
               end
            end
            IRS_VEC: begin
               d.pc_load = 1'b1;
               d.st = IRS_IDLE;
            end
            IRS_POP: begin
               d.pop = 1'b1;
               d.sel = `IRS_SEL_CC - q.step;
               d.step = q.step + 3'h1;
               if (q.step == `IRS_LAST_STEP) begin
                  d.st = IRS_IDLE;
                  d.imask = 1'b0;
               end
            end
            default: begin
               d.st = IRS_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // state register
   // ==========================================================
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '{st: IRS_IDLE, misc: `IRS_MISC_RST, default: '0};
      end else begin
         q <= d;
      end
   end

   // outputs from the state register
   assign rdata            = q.rdata;
   assign imask            = q.imask;
   assign stk_push         = q.push;
   assign stk_pop          = q.pop;
   assign stk_sel          = q.sel;
   assign pc_load          = q.pc_load;
   assign pc_vector        = q.vec;
   assign clock_out_enable = q.misc[`IRS_B_MCO];
   assign cpu_divider_sel  = {q.misc[`IRS_B_CP1], q.misc[`IRS_B_CP0]};
   assign slow_mode_select = q.misc[`IRS_B_SMS];

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   lvd_flag_set_a: assert property (
      ce && !halt_mode && supply_drop_rst |=> q.supply_drop_detector && !q.wdg)
      else $error("supply-drop flag not set");
   wdg_flag_set_a: assert property (
      ce && !halt_mode && watchdog_rst && !supply_drop_rst |=> q.wdg && !q.supply_drop_detector)
      else $error("watchdog flag not set");
   stat_read_a: assert property (
      rd && ce && addr == `IRS_ADR_STAT |=> rdata[7:5] == 3'h0 && rdata[3] == 1'b0
      && rdata[`IRS_B_LVD] == $past(q.supply_drop_detector))
      else $error("status read wrong");
   backup_osc_active_flag_clear_a: assert property (
      ce && !halt_mode && rd && addr == `IRS_ADR_STAT && !backup_osc_sel |=> !q.backup_osc_active_flag)
      else $error("backup flag not cleared");
   masked_hold_a: assert property (
      q.st == IRS_IDLE && q.imask && !trap_exec |=> q.st != IRS_PUSH)
      else $error("entry while masked");
   entry_wait_a: assert property (
      q.st == IRS_IDLE && !instr_end |=> q.st != IRS_PUSH)
      else $error("entry before instruction end");
   push_seq_a: assert property (
      ce && q.st == IRS_PUSH && q.step == 3'h0 |=> stk_push [*5] ##1 pc_load)
      else $error("push sequence wrong");
   mask_entry_a: assert property (
      $rose(pc_load) |-> imask)
      else $error("mask not set on entry");
   trap_entry_a: assert property (
      ce && q.st == IRS_IDLE && instr_end && trap_exec |=> q.vec == `IRS_VEC_TRAP)
      else $error("trap not entered");
   halt_frozen_a: assert property (
      halt_mode && ce ##1 1'b1 |-> $stable({q.supply_drop_detector, q.wdg, q.backup_osc_active_flag, q.clock_guard_irq_enable}))
      else $error("status changed in halt");

   trap_cov: cover property (pc_load && q.src == `IRS_SRC_TRAP);
   ext_cov: cover property (pc_load && q.src == 4'h0);
   return_from_interrupt_cov: cover property (q.st == IRS_POP ##1 q.st == IRS_IDLE);
   halt_wake_cov: cover property (wake_halt);

endmodule // irs_ctrl

// *** irs_cpu_model.sv ***
`timescale 1ns/100ps
// ==========================================
// cpu side: counts stacked bytes, checks order
module irs_cpu_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // stack strobes from the controller
   input  wire logic       stk_push,
   input  wire logic       stk_pop,
   input  wire logic [2:0] stk_sel,
   // byte counts and order fault
   output logic [7:0]      pushes,
   output logic [7:0]      pops,
   output logic            bad
);
   // push order pcl..cc, pop order reversed; a slip sticks in bad
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pushes <= 8'h00;
         pops <= 8'h00;
         bad <= 1'b0;
      end else begin
         if (stk_push) begin
            pushes <= pushes + 8'h01;
            if (stk_sel != 3'(pushes % 8'h05)) bad <= 1'b1;
         end
         if (stk_pop) begin
            pops <= pops + 8'h01;
            if (stk_sel != 3'(8'h04 - pops % 8'h05)) bad <= 1'b1;
         end
      end
   end
endmodule // irs_cpu_model

// *** irs_ctrl_tb_top.sv ***
`timescale 1ns/100ps
`include "irs_cfg.svh"
// ==========================================
// bench: register and cpu-side sequences
module irs_ctrl_tb_top;
   logic        clk, arst_n, ce, wr, rd, supply_drop_rst, watchdog_rst, backup_osc_sel;
   logic        instr_end, trap_exec, return_from_interrupt, mask_set, mask_clr;
   logic        wait_mode, halt_mode, imask, stk_push, stk_pop, pc_load, bad;
   logic        wake_wait, wake_halt, clock_out_enable, slow_mode_select;
   logic [1:0]  cpu_divider_sel;
   logic [2:0]  stk_sel;
   logic [6:0]  per_flag, per_en, per_clr;
   logic [7:0]  addr, wdata, rdata, ei0_pin, ei0_en, ei1_pin, ei1_en, pushes, pops;
   logic [15:0] pc_vector;
   int          err_count, cmp_count, cyc, n_ent;

   // ==========================================
   // design, cpu model
   irs_ctrl dut_u (.clk, .arst_n, .ce, .addr, .wdata, .wr, .rd, .rdata,
      .supply_drop_rst, .watchdog_rst, .backup_osc_sel, .ei0_pin, .ei0_en,
      .ei1_pin, .ei1_en, .per_flag, .per_en, .per_clr, .instr_end,
      .trap_exec, .return_from_interrupt, .mask_set, .mask_clr, .wait_mode,
      .halt_mode, .imask, .stk_push, .stk_pop, .stk_sel, .pc_load, .pc_vector,
      .wake_wait, .wake_halt, .clock_out_enable, .cpu_divider_sel, .slow_mode_select);
   irs_cpu_model mdl_u (.clk, .arst_n, .stk_push, .stk_pop, .stk_sel, .pushes, .pops, .bad);

   // ==========================================
   // tasks
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task tk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task bus_w(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stands in the cycle after the strobe
   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rdata", {8'h00, e}, {8'h00, rdata});
   endtask
   // one-cycle pulses: supply drop, watchdog, mask set, mask clear; clears
   task pls(input logic [3:0] v, input logic [6:0] c);
      @(posedge clk);
      {supply_drop_rst, watchdog_rst, mask_set, mask_clr} <= v;
      per_clr <= c;
      @(posedge clk);
      {supply_drop_rst, watchdog_rst, mask_set, mask_clr} <= 4'h0;
      per_clr <= 7'h00;
   endtask
   // end an instruction, expect entry or not
   task enter(input logic t, input logic go, input logic [15:0] v);
      logic seen;
      seen = 1'b0;
      @(posedge clk);
      instr_end <= 1'b1;
      trap_exec <= t;
      @(posedge clk);
      instr_end <= 1'b0;
      trap_exec <= 1'b0;
      repeat (10) begin
         @(posedge clk);
         #1;
         if (pc_load === 1'b1) seen = 1'b1;
      end
      n_ent += go;
      chk("entry", 16'(go), 16'(seen));
      chk("pushes", 16'(5 * n_ent), {8'h00, pushes});
      if (go) begin
         chk("vector", v, pc_vector);
         chk("imask", 16'h1, {15'h0, imask});
      end
   endtask
   task ret;
      @(posedge clk);
      return_from_interrupt <= 1'b1;
      @(posedge clk);
      return_from_interrupt <= 1'b0;
      tk(8);
      #1;
      chk("pops", 16'(5 * n_ent), {8'h00, pops});
      chk("imask", 16'h0, {15'h0, imask});
   endtask
   task close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // ==========================================
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         close_out;
      end
   end

   // ==========================================
   // main sequence
   initial begin
      arst_n = 1'b0;
      {wr, rd, supply_drop_rst, watchdog_rst, backup_osc_sel, instr_end} = 6'h00;
      {trap_exec, return_from_interrupt, mask_set, mask_clr, wait_mode, halt_mode} = 6'h00;
      {addr, wdata, ei0_en, per_flag, per_en, per_clr} = 45'h0;
      ei0_pin = 8'hff;
      ei1_pin = 8'hff;
      ei1_en = 8'h00;
      ce = 1'b1;
      tk(2);
      arst_n <= 1'b1;
      // register map and reset values
      rd_chk(`IRS_ADR_MISC, 8'h00);
      rd_chk(`IRS_ADR_STAT, 8'h00);
      bus_w(`IRS_ADR_MISC, 8'ha5);
      rd_chk(`IRS_ADR_MISC, 8'ha5);
      chk("clk_out", 16'h1, {15'h0, clock_out_enable});
      chk("div_sel", 16'h2, {14'h0, cpu_divider_sel});
      chk("slow", 16'h1, {15'h0, slow_mode_select});
      bus_w(`IRS_ADR_MISC, 8'h00);
      bus_w(8'h21, 8'hff);
      rd_chk(8'h21, 8'h00);
      // clock enable low: a write must not land
      @(posedge clk);
      ce <= 1'b0;
      bus_w(`IRS_ADR_MISC, 8'hff);
      @(posedge clk);
      ce <= 1'b1;
      rd_chk(`IRS_ADR_MISC, 8'h00);
      // reset source flags
      pls(4'h4, 7'h00);
      rd_chk(`IRS_ADR_STAT, 8'h01);
      pls(4'h8, 7'h00);
      rd_chk(`IRS_ADR_STAT, 8'h10);
      bus_w(`IRS_ADR_STAT, 8'hff);
      rd_chk(`IRS_ADR_STAT, 8'h14);
      pls(4'h4, 7'h00);
      rd_chk(`IRS_ADR_STAT, 8'h05);
      bus_w(`IRS_ADR_STAT, 8'h04);
      rd_chk(`IRS_ADR_STAT, 8'h04);
      // clock guard flag and enable
      @(posedge clk);
      backup_osc_sel <= 1'b1;
      wait_mode <= 1'b1;
      rd_chk(`IRS_ADR_STAT, 8'h06);
      chk("wake_wait", 16'h1, {15'h0, wake_wait});
      bus_w(`IRS_ADR_STAT, 8'h00);
      rd_chk(`IRS_ADR_STAT, 8'h02);
      chk("wake_wait", 16'h0, {15'h0, wake_wait});
      @(posedge clk);
      backup_osc_sel <= 1'b0;
      wait_mode <= 1'b0;
      rd_chk(`IRS_ADR_STAT, 8'h02);
      rd_chk(`IRS_ADR_STAT, 8'h00);
      // masked peripheral, entry, return, clear
      pls(4'h2, 7'h00);
      @(posedge clk);
      per_flag <= 7'h01;
      per_en <= 7'h01;
      enter(1'b0, 1'b0, 16'h0);
      pls(4'h1, 7'h00);
      tk(10);
      #1;
      chk("pushes", 16'h0, {8'h00, pushes});
      enter(1'b0, 1'b1, 16'hfff4);
      ret;
      pls(4'h0, 7'h01);
      enter(1'b0, 1'b0, 16'h0);
      // disabled pending, priority, trap
      @(posedge clk);
      per_flag <= 7'h03;
      enter(1'b0, 1'b0, 16'h0);
      @(posedge clk);
      per_en <= 7'h03;
      ei0_en <= 8'h01;
      ei0_pin <= 8'hfe;
      enter(1'b0, 1'b1, 16'hfffa);
      ret;
      @(posedge clk);
      ei0_pin <= 8'hff;
      pls(4'h2, 7'h00);
      enter(1'b1, 1'b1, 16'hfffc);
      ret;
      enter(1'b0, 1'b1, 16'hfff2);
      ret;
      pls(4'h0, 7'h02);
      // low power wake and halt freeze
      @(posedge clk);
      per_flag <= 7'h00;
      @(posedge clk);
      per_flag <= 7'h01;
      wait_mode <= 1'b1;
      tk(2);
      #1;
      chk("wake_wait", 16'h1, {15'h0, wake_wait});
      @(posedge clk);
      wait_mode <= 1'b0;
      halt_mode <= 1'b1;
      pls(4'h8, 7'h00);
      rd_chk(`IRS_ADR_STAT, 8'h00);
      chk("wake_halt", 16'h0, {15'h0, wake_halt});
      @(posedge clk);
      ei0_pin <= 8'hfe;
      tk(1);
      #1;
      chk("wake_halt", 16'h1, {15'h0, wake_halt});
      @(posedge clk);
      halt_mode <= 1'b0;
      ei0_pin <= 8'hff;
      pls(4'h0, 7'h01);
      // anded pins, rising edge latch
      bus_w(`IRS_ADR_MISC, 8'h08);
      @(posedge clk);
      ei0_en <= 8'h03;
      ei0_pin <= 8'hfe;
      @(posedge clk);
      ei0_pin <= 8'hfc;
      @(posedge clk);
      ei0_pin <= 8'hfe;
      enter(1'b0, 1'b0, 16'h0);
      @(posedge clk);
      ei0_pin <= 8'hff;
      enter(1'b0, 1'b1, 16'hfffa);
      ret;
      enter(1'b0, 1'b0, 16'h0);
      // second line, falling edge latch
      bus_w(`IRS_ADR_MISC, 8'h80);
      @(posedge clk);
      ei1_en <= 8'h01;
      @(posedge clk);
      ei1_pin <= 8'hfe;
      enter(1'b0, 1'b1, 16'hfff8);
      ret;
      @(posedge clk);
      ei1_pin <= 8'hff;
      enter(1'b0, 1'b0, 16'h0);
      chk("order", 16'h0, {15'h0, bad});
      close_out;
   end
endmodule // irs_ctrl_tb_top
